/* File: hdl/dssp_pkg.sv */
// constants, types and companding helpers for the dual serial port block
package dssp_pkg;
  // register byte addresses
  localparam logic [6:0] A_SYS = 7'h00;
  localparam logic [6:0] A_ISTAT = 7'h04;
  localparam logic [6:0] A_IMASK = 7'h08;
  localparam logic [6:0] A_STAT = 7'h0C;
  // port windows sit at 7'h20 (port zero) and 7'h40 (port one)
  localparam logic [4:0] O_CTRL = 5'h00;
  localparam logic [4:0] O_DIV = 5'h04;
  localparam logic [4:0] O_TXD = 5'h08;
  localparam logic [4:0] O_RXD = 5'h0C;
  localparam logic [4:0] O_ABUF = 5'h10;
  localparam logic [4:0] O_MCM = 5'h14;
  // section control field, rx half at bit 0, tx half at bit 16
  localparam int F_TXH = 16;
  localparam int F_EN = 0;
  localparam int F_WL = 1;
  localparam int F_FM = 5;
  localparam int F_INV = 7;
  localparam int F_LATE = 8;
  localparam int F_WIDE = 9;
  localparam int F_CMP = 10;
  localparam int F_ABUF = 12;
  localparam int F_ICLK = 13;
  localparam int F_MC = 14;
  localparam int F_MC32 = 15;
  localparam logic [1:0] FM_NONE = 2'h0;
  localparam logic [1:0] FM_INT = 2'h1;
  localparam logic [1:0] FM_EXT = 2'h2;
  localparam logic [1:0] CMP_MU = 2'h2;
  localparam logic [1:0] CMP_A = 2'h3;
  // system control bits
  localparam int S_ALT = 0;
  localparam int S_EDGA = 1;
  localparam int S_EDGB = 2;
  localparam int S_FO = 3;
  // interrupt bits: 0..3 sections (p0 rx, p0 tx, p1 rx, p1 tx), 4..5 alt inputs
  localparam int I_ALTA = 4;
  localparam int I_ALTB = 5;
  localparam logic [3:0] WL_MIN_M1 = 4'h2;
  localparam logic [4:0] MC_LAST_24 = 5'h17;
  localparam logic [4:0] MC_LAST_32 = 5'h1F;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DIV_RST = 16'h0003;
  localparam logic [15:0] ABUF_RST = 16'h0000;
  localparam logic [15:0] MU_CLIP = 16'h7F7B;
  localparam logic [15:0] A_CLIP = 16'h7FFF;
  localparam logic [15:0] MU_BIAS = 16'h0084;

  typedef enum logic {DSSP_IDLE, DSSP_SHIFT} dssp_sect_st_t;

  // linear 16-bit to 8-bit log code
  function automatic logic [7:0] dssp_compress(input logic [15:0] x, input logic alaw);
    logic s;
    logic [15:0] m;
    logic [15:0] v;
    logic [2:0] seg;
    logic [3:0] man;
    s = x[15];
    m = s ? (~x + 16'h0001) : x;
    if (alaw)
      v = (m > A_CLIP) ? A_CLIP : m;
    else
      v = ((m > MU_CLIP) ? MU_CLIP : m) + MU_BIAS;
    seg = 3'h0;
    for (int i = 0; i < 8; i++)
      if (v[i + 7] && (!alaw || i > 0))
        seg = 3'(i);
    if (alaw && seg == 3'h0)
      man = v[7:4];
    else
      man = 4'(v >> ({1'b0, seg} + 4'h3));
    dssp_compress = alaw ? ({~s, seg, man} ^ 8'h55) : ~{s, seg, man};
  endfunction

  // 8-bit log code to linear 16-bit
  function automatic logic [15:0] dssp_expand(input logic [7:0] c, input logic alaw);
    logic [7:0] u;
    logic [15:0] t;
    u = alaw ? (c ^ 8'h55) : ~c;
    if (alaw)
    begin
      t = {8'h00, u[3:0], 4'h8};
      if (u[6:4] != 3'h0)
        t = (t + 16'h0100) << (u[6:4] - 3'h1);
      dssp_expand = u[7] ? t : (~t + 16'h0001);
    end
    else
    begin
      t = ({9'h000, u[3:0], 3'h0} + MU_BIAS) << u[6:4];
      dssp_expand = u[7] ? (MU_BIAS - t) : (t - MU_BIAS);
    end
  endfunction
endpackage

/* File: hdl/dssp_top.sv */
// dual synchronous serial port: register file, clocks, sections, alt pins
// Function
// - two ports, each with its own double-buffered transmit and receive section.
// - each port makes its bit clock from mclk or takes the bit clock from the far end.
// - each section runs frameless, with internal frame sync, or with external frame sync.
// - frame sync polarity is selectable, and so are its width (bit or word) and timing (early or late).
// - word length is programmable from three to sixteen bits for each section.
// - optional mu-law or A-law companding on transmit and receive.
// - each section raises its own interrupt when a word has been moved.
// - autobuffer mode counts each section's words against a buffer length held in the autobuffer register.
// - in autobuffer mode the interrupt comes once per whole buffer, not per word.
// - port zero can select chosen words of a 24- or 32-word multiplexed frame.
// - port one can turn its pins into two interrupt inputs, a flag input and a flag output.
// - in that alternate setup the internal bit clock of port one stays available.
// - pin functions can be changed by software at any time.
// - port one's function is chosen by a bit of the system control register.
// - each alternate interrupt input is edge- or level-sensitive.
// - in the alternate setup the receive data pin is the flag input, the transmit data pin the flag output.
`timescale 1ns/1ps

// one transmit or receive section
module dssp_sect #(
  parameter bit TX = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic rise,
  input wire logic fall,
  input wire logic fs_in,
  input wire logic sd_in,
  input wire logic [3:0] wlm1,
  input wire logic [1:0] fmode,
  input wire logic late,
  input wire logic wide,
  input wire logic mc,
  input wire logic mc32,
  input wire logic [31:0] mc_mask,
  input wire logic [15:0] tx_word,
  input wire logic tx_valid,
  output logic sd_out,
  output logic sd_oe,
  output logic fs_out,
  output logic take,
  output logic done,
  output logic [15:0] rx_word
);
  dssp_pkg::dssp_sect_st_t st_r;
  logic [15:0] sh_r;
  logic [3:0] cnt_r;
  logic [4:0] chan_r;
  logic frm_r;
  logic loaded_r;

  // word length clamped at three bits
  wire [3:0] wl = (wlm1 < dssp_pkg::WL_MIN_M1) ? dssp_pkg::WL_MIN_M1 : wlm1;
  wire busy = (st_r == dssp_pkg::DSSP_SHIFT);
  wire frameless = (fmode == dssp_pkg::FM_NONE);
  wire ch_on = ~mc | mc_mask[chan_r];
  wire [4:0] chan_last = mc32 ? dssp_pkg::MC_LAST_32 : dssp_pkg::MC_LAST_24;
  wire ready = TX ? loaded_r : 1'b1;
  // start condition per framing mode
  wire base_trig = frameless ? 1'b1 : (fmode == dssp_pkg::FM_INT) ? fs_out : fs_in;
  wire trig = frm_r | base_trig;
  wire late_eff = late | frameless | frm_r;
  wire consume = fall & (busy | (trig & late_eff));
  wire last = consume & (cnt_r == wl);
  wire [15:0] rx_mask = 16'hFFFF >> (4'hF - wl);

  // bit counter, word state and multichannel slot counter
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= dssp_pkg::DSSP_IDLE;
      cnt_r <= 4'h0;
      chan_r <= 5'h00;
      frm_r <= 1'b0;
    end
    else if (!en)
    begin
      st_r <= dssp_pkg::DSSP_IDLE;
      cnt_r <= 4'h0;
      frm_r <= 1'b0;
    end
    else if (fall)
    begin
      if (consume)
        cnt_r <= last ? 4'h0 : cnt_r + 4'h1;
      if (!busy && trig)
      begin
        st_r <= dssp_pkg::DSSP_SHIFT;
        if (!frm_r)
        begin
          chan_r <= 5'h00;
          frm_r <= mc;
        end
      end
      if (last)
      begin
        st_r <= dssp_pkg::DSSP_IDLE;
        if (frm_r && chan_r == chan_last)
          frm_r <= 1'b0;
        else if (frm_r)
          chan_r <= chan_r + 5'h01;
      end
    end
  end

  // shift register with holding word behind it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_r <= 16'h0000;
      loaded_r <= 1'b0;
      take <= 1'b0;
      done <= 1'b0;
      rx_word <= 16'h0000;
    end
    else
    begin
      take <= 1'b0;
      done <= 1'b0;
      if (TX && en && !loaded_r && tx_valid && !busy && !consume)
      begin
        sh_r <= tx_word << (4'hF - wl);
        loaded_r <= 1'b1;
        take <= 1'b1;
      end
      else if (consume && ch_on)
        sh_r <= {sh_r[14:0], TX ? 1'b0 : sd_in};
      if (last && ch_on)
      begin
        done <= 1'b1;
        loaded_r <= 1'b0;
        if (!TX)
          rx_word <= {sh_r[14:0], sd_in} & rx_mask;
      end
      if (!en)
        loaded_r <= 1'b0;
    end
  end

  // data and internal frame sync change on the rising bit clock edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sd_out <= 1'b0;
      sd_oe <= 1'b0;
      fs_out <= 1'b0;
    end
    else if (rise)
    begin
      sd_out <= sh_r[15];
      sd_oe <= TX & en & ch_on & (busy | loaded_r);
      fs_out <= en & (fmode == dssp_pkg::FM_INT) & ~frm_r & ((~busy & ready) | (wide & busy));
    end
  end
endmodule

// top: register port, pins of both serial ports
module dssp_top #(
  parameter int DIVW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [1:0] sclk_i,
  output logic [1:0] sclk_o,
  output logic [1:0] sclk_oe,
  input wire logic [1:0] rfs_i,
  output logic [1:0] rfs_o,
  output logic [1:0] rfs_oe,
  input wire logic [1:0] tfs_i,
  output logic [1:0] tfs_o,
  output logic [1:0] tfs_oe,
  input wire logic [1:0] dr_i,
  output logic [1:0] dt_o,
  output logic [1:0] dt_oe
);
  logic [31:0] ctrl_r [2];
  logic [DIVW-1:0] div_r [2];
  logic [DIVW-1:0] dcnt_r [2];
  logic [15:0] txh_r [2];
  logic [15:0] rxh_r [2];
  logic [15:0] abl_r [2];
  logic [7:0] abc_r [4];
  logic [31:0] mcm_r;
  logic [3:0] sys_r;
  logic [5:0] ist_r;
  logic [5:0] imsk_r;
  logic [1:0] txf_r;
  logic [1:0] rxf_r;
  logic [1:0] sclk_int_r;
  logic [1:0] ckprev_r;
  logic [1:0] altprev_r;
  logic [7:0] meta_r;
  logic [7:0] syn_r;

  wire [1:0] iclk;
  wire [1:0] ck_now;
  wire [1:0] rise;
  wire [1:0] fall;
  wire [3:0] en_s;
  wire [3:0] take_s;
  wire [3:0] done_s;
  wire [3:0] last_buf;
  wire [3:0] sd_s;
  wire [3:0] sdoe_s;
  wire [3:0] fso_s;
  wire [3:0][15:0] rxw_s;
  wire [3:0][15:0] txw_s;
  wire [1:0][15:0] rx_store;
  wire [1:0] sclk_o_nxt;
  wire [1:0] rfs_o_nxt;
  wire [1:0] rfs_oe_nxt;
  wire [1:0] tfs_o_nxt;
  wire [1:0] tfs_oe_nxt;
  wire [1:0] dt_o_nxt;
  wire [1:0] dt_oe_nxt;
  wire [5:0] ev;

  // register address decode
  wire pidx = reg_addr[6];
  wire port_hit = reg_addr[6] ^ reg_addr[5];
  wire [4:0] off = reg_addr[4:0];
  wire wp = reg_wr & port_hit;
  wire rp = reg_rd & port_hit;
  wire alt = sys_r[dssp_pkg::S_ALT];
  wire alt_interrupt_in_a = syn_r[3];
  wire alt_interrupt_in_b = syn_r[5];
  wire alt_flag_input = syn_r[7];
  wire alt_flag_output = sys_r[dssp_pkg::S_FO];

  // alternate interrupt inputs, active low, edge or level
  assign ev[dssp_pkg::I_ALTA] = alt & (sys_r[dssp_pkg::S_EDGA] ? (altprev_r[0] & ~alt_interrupt_in_a)
                                                           : ~alt_interrupt_in_a);
  assign ev[dssp_pkg::I_ALTB] = alt & (sys_r[dssp_pkg::S_EDGB] ? (altprev_r[1] & ~alt_interrupt_in_b)
                                                           : ~alt_interrupt_in_b);

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      wire [15:0] rxc = ctrl_r[p][15:0];
      wire [15:0] txc = ctrl_r[p][31:16];
      wire off_alt = (p == 1) & alt;
      wire mc = (p == 0) & rxc[dssp_pkg::F_MC];
      wire rx_inv = rxc[dssp_pkg::F_INV];
      wire tx_inv = txc[dssp_pkg::F_INV];
      wire rx_fs = syn_r[2 + p] ^ rx_inv;
      wire tx_fs = mc ? rx_fs : syn_r[4 + p] ^ tx_inv;

      // bit clock selection and edge finding
      assign iclk[p] = rxc[dssp_pkg::F_ICLK];
      assign ck_now[p] = iclk[p] ? sclk_int_r[p] : syn_r[p];
      assign rise[p] = ck_now[p] & ~ckprev_r[p];
      assign fall[p] = ~ck_now[p] & ckprev_r[p];
      assign en_s[2 * p] = rxc[dssp_pkg::F_EN] & ~off_alt;
      assign en_s[2 * p + 1] = txc[dssp_pkg::F_EN] & ~off_alt;

      // companding on both directions
      assign txw_s[2 * p + 1] = txc[dssp_pkg::F_CMP + 1] ?
        {8'h00, dssp_pkg::dssp_compress(txh_r[p], txc[dssp_pkg::F_CMP])} : txh_r[p];
      assign rx_store[p] = rxc[dssp_pkg::F_CMP + 1] ?
        dssp_pkg::dssp_expand(rxw_s[2 * p][7:0], rxc[dssp_pkg::F_CMP]) : rxw_s[2 * p];
      assign txw_s[2 * p] = 16'h0000;

      // per-word or per-buffer event
      assign last_buf[2 * p] = ~rxc[dssp_pkg::F_ABUF] | ({1'b0, abc_r[2 * p]} + 9'h001 >= {1'b0, abl_r[p][7:0]});
      assign last_buf[2 * p + 1] = ~txc[dssp_pkg::F_ABUF] |
        ({1'b0, abc_r[2 * p + 1]} + 9'h001 >= {1'b0, abl_r[p][15:8]});
      assign ev[2 * p] = done_s[2 * p] & last_buf[2 * p];
      assign ev[2 * p + 1] = done_s[2 * p + 1] & last_buf[2 * p + 1];

      // next pin values, alternate function on port one
      assign sclk_o_nxt[p] = sclk_int_r[p];
      assign rfs_o_nxt[p] = fso_s[2 * p] ^ rx_inv;
      assign rfs_oe_nxt[p] = en_s[2 * p] & (rxc[dssp_pkg::F_FM +: 2] == dssp_pkg::FM_INT);
      assign tfs_o_nxt[p] = fso_s[2 * p + 1] ^ tx_inv;
      assign tfs_oe_nxt[p] = en_s[2 * p + 1] & ~mc & (txc[dssp_pkg::F_FM +: 2] == dssp_pkg::FM_INT);
      assign dt_o_nxt[p] = off_alt ? alt_flag_output : sd_s[2 * p + 1];
      assign dt_oe_nxt[p] = off_alt | sdoe_s[2 * p + 1];

      dssp_sect #(.TX(1'b0)) u_rx (
        .mclk(mclk),
        .rst_n(rst_n),
        .en(en_s[2 * p]),
        .rise(rise[p]),
        .fall(fall[p]),
        .fs_in(rx_fs),
        .sd_in(syn_r[6 + p]),
        .wlm1(rxc[dssp_pkg::F_WL +: 4]),
        .fmode(rxc[dssp_pkg::F_FM +: 2]),
        .late(rxc[dssp_pkg::F_LATE]),
        .wide(rxc[dssp_pkg::F_WIDE]),
        .mc(mc),
        .mc32(rxc[dssp_pkg::F_MC32]),
        .mc_mask(mcm_r),
        .tx_word(txw_s[2 * p]),
        .tx_valid(1'b0),
        .sd_out(sd_s[2 * p]),
        .sd_oe(sdoe_s[2 * p]),
        .fs_out(fso_s[2 * p]),
        .take(take_s[2 * p]),
        .done(done_s[2 * p]),
        .rx_word(rxw_s[2 * p])
      );

      dssp_sect #(.TX(1'b1)) u_tx (
        .mclk(mclk),
        .rst_n(rst_n),
        .en(en_s[2 * p + 1]),
        .rise(rise[p]),
        .fall(fall[p]),
        .fs_in(tx_fs),
        .sd_in(1'b0),
        .wlm1(txc[dssp_pkg::F_WL +: 4]),
        .fmode(mc ? rxc[dssp_pkg::F_FM +: 2] : txc[dssp_pkg::F_FM +: 2]),
        .late(txc[dssp_pkg::F_LATE]),
        .wide(txc[dssp_pkg::F_WIDE]),
        .mc(mc),
        .mc32(rxc[dssp_pkg::F_MC32]),
        .mc_mask(mcm_r),
        .tx_word(txw_s[2 * p + 1]),
        .tx_valid(txf_r[p]),
        .sd_out(sd_s[2 * p + 1]),
        .sd_oe(sdoe_s[2 * p + 1]),
        .fs_out(fso_s[2 * p + 1]),
        .take(take_s[2 * p + 1]),
        .done(done_s[2 * p + 1]),
        .rx_word(rxw_s[2 * p + 1])
      );
    end
  endgenerate

  // read data selection
  wire [31:0] prd = (off == dssp_pkg::O_CTRL) ? ctrl_r[pidx] :
                    (off == dssp_pkg::O_DIV) ? 32'(div_r[pidx]) :
                    (off == dssp_pkg::O_TXD) ? {16'h0000, txh_r[pidx]} :
                    (off == dssp_pkg::O_RXD) ? {16'h0000, rxh_r[pidx]} :
                    (off == dssp_pkg::O_ABUF) ? {16'h0000, abl_r[pidx]} :
                    (off == dssp_pkg::O_MCM && !pidx) ? mcm_r : 32'h0000_0000;
  wire [31:0] rd_mux = port_hit ? prd :
                       (reg_addr == dssp_pkg::A_SYS) ? {28'h0000000, sys_r} :
                       (reg_addr == dssp_pkg::A_ISTAT) ? {26'h0, ist_r} :
                       (reg_addr == dssp_pkg::A_IMASK) ? {26'h0, imsk_r} :
                       (reg_addr == dssp_pkg::A_STAT) ? {27'h0, alt_flag_input, rxf_r[1], txf_r[1],
                                                         rxf_r[0], txf_r[0]} : 32'h0000_0000;
  wire [5:0] w1c = (reg_wr && reg_addr == dssp_pkg::A_ISTAT) ? reg_wdata[5:0] : 6'h00;

  // two-flop synchronisers for all pin inputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 8'h00;
      syn_r <= 8'h00;
    end
    else
    begin
      meta_r <= {dr_i, tfs_i, rfs_i, sclk_i};
      syn_r <= meta_r;
    end
  end

  // internal bit clock dividers, half period of div+1 mclk
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 2; i++)
      begin
        dcnt_r[i] <= '0;
      end
      sclk_int_r <= 2'h0;
      ckprev_r <= 2'h0;
      altprev_r <= 2'h3;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (dcnt_r[i] >= div_r[i])
        begin
          dcnt_r[i] <= '0;
          sclk_int_r[i] <= ~sclk_int_r[i];
        end
        else
          dcnt_r[i] <= dcnt_r[i] + DIVW'(1);
      end
      ckprev_r <= ck_now;
      altprev_r <= {alt_interrupt_in_b, alt_interrupt_in_a};
    end
  end

  // software-written registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 2; i++)
      begin
        ctrl_r[i] <= dssp_pkg::CTRL_RST;
        div_r[i] <= DIVW'(dssp_pkg::DIV_RST);
        txh_r[i] <= 16'h0000;
        abl_r[i] <= dssp_pkg::ABUF_RST;
      end
      mcm_r <= 32'h0000_0000;
      sys_r <= 4'h0;
      imsk_r <= 6'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == dssp_pkg::A_SYS)
        sys_r <= reg_wdata[3:0];
      if (reg_wr && reg_addr == dssp_pkg::A_IMASK)
        imsk_r <= reg_wdata[5:0];
      if (wp && !pidx && off == dssp_pkg::O_MCM)
        mcm_r <= reg_wdata;
      for (int i = 0; i < 2; i++)
      begin
        if (wp && pidx == 1'(i) && off == dssp_pkg::O_CTRL)
          ctrl_r[i] <= reg_wdata;
        if (wp && pidx == 1'(i) && off == dssp_pkg::O_DIV)
          div_r[i] <= reg_wdata[DIVW-1:0];
        if (wp && pidx == 1'(i) && off == dssp_pkg::O_TXD)
          txh_r[i] <= reg_wdata[15:0];
        if (wp && pidx == 1'(i) && off == dssp_pkg::O_ABUF)
          abl_r[i] <= reg_wdata[15:0];
      end
    end
  end

  // holding buffer flags and autobuffer word counters
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txf_r <= 2'h0;
      rxf_r <= 2'h0;
      for (int i = 0; i < 2; i++)
      begin
        rxh_r[i] <= 16'h0000;
      end
      for (int s = 0; s < 4; s++)
      begin
        abc_r[s] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        txf_r[i] <= (wp && pidx == 1'(i) && off == dssp_pkg::O_TXD) | (txf_r[i] & ~take_s[2 * i]
                    & ~take_s[2 * i + 1]);
        rxf_r[i] <= done_s[2 * i] | (rxf_r[i] & ~(rp && pidx == 1'(i) && off == dssp_pkg::O_RXD));
        if (done_s[2 * i])
          rxh_r[i] <= rx_store[i];
      end
      for (int s = 0; s < 4; s++)
      begin
        if (done_s[s])
          abc_r[s] <= last_buf[s] ? 8'h00 : abc_r[s] + 8'h01;
      end
    end
  end

  // sticky interrupt status, a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_r <= 6'h00;
      irq <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      ist_r <= (ist_r & ~w1c) | ev;
      irq <= |(((ist_r & ~w1c) | ev) & imsk_r);
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // registered pin outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_o <= 2'h0;
      sclk_oe <= 2'h0;
      rfs_o <= 2'h0;
      rfs_oe <= 2'h0;
      tfs_o <= 2'h0;
      tfs_oe <= 2'h0;
      dt_o <= 2'h0;
      dt_oe <= 2'h0;
    end
    else
    begin
      sclk_o <= sclk_o_nxt;
      sclk_oe <= iclk;
      rfs_o <= rfs_o_nxt;
      rfs_oe <= rfs_oe_nxt;
      tfs_o <= tfs_o_nxt;
      tfs_oe <= tfs_oe_nxt;
      dt_o <= dt_o_nxt;
      dt_oe <= dt_oe_nxt;
    end
  end
endmodule

/* File: testbench/dssp_properties.sv */
// concurrent checks on the register port and pins of the dual serial port
`timescale 1ns/1ps
module dssp_props #(
  parameter int DIVW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic [1:0] sclk_oe,
  input wire logic [1:0] rfs_oe,
  input wire logic [1:0] tfs_oe,
  input wire logic [1:0] dt_o,
  input wire logic [1:0] dt_oe
);
  logic [31:0] c0_r;
  logic iclk1_r;
  logic alt_r;
  logic fo_r;
  logic mask_wr;
  logic mask_off;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // mask writes seen on the register port
  assign mask_wr = reg_wr && reg_addr == dssp_pkg::A_IMASK;
  assign mask_off = mask_wr && reg_wdata[5:0] == 6'h00;
  // shadow copies of control bits written by software
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      c0_r <= 32'h0000_0000;
      iclk1_r <= 1'b0;
      alt_r <= 1'b0;
      fo_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 7'h20)
        c0_r <= reg_wdata;
      if (reg_addr == 7'h40)
        iclk1_r <= reg_wdata[13];
      if (reg_addr == dssp_pkg::A_SYS)
      begin
        alt_r <= reg_wdata[0];
        fo_r <= reg_wdata[3];
      end
    end
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read slot");
  property p_unmapped;
    $past(reg_rd) && $past(reg_addr) == 7'h7C |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_irq_off;
    mask_off ##1 !mask_wr |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with all sources masked");
  property p_alt_fo;
    alt_r && $stable(alt_r) && $stable(fo_r) |-> dt_oe[1] && dt_o[1] == fo_r;
  endproperty
  a_alt_fo: assert property (p_alt_fo)
    else $error("flag output pin wrong");
  property p_sclk0;
    $stable(c0_r[13]) |-> sclk_oe[0] == c0_r[13];
  endproperty
  a_sclk0: assert property (p_sclk0)
    else $error("port zero clock enable wrong");
  property p_sclk1_alt;
    alt_r && $stable(iclk1_r) |-> sclk_oe[1] == iclk1_r;
  endproperty
  a_sclk1_alt: assert property (p_sclk1_alt)
    else $error("port one clock enable wrong in alt mode");
  property p_rfs_oe;
    $stable(c0_r) |-> rfs_oe[0] == (c0_r[0] && c0_r[6:5] == dssp_pkg::FM_INT);
  endproperty
  a_rfs_oe: assert property (p_rfs_oe)
    else $error("rx frame enable wrong");
  property p_tfs_oe;
    $stable(c0_r) |-> tfs_oe[0] == (c0_r[16] && c0_r[22:21] == dssp_pkg::FM_INT && !c0_r[14]);
  endproperty
  a_tfs_oe: assert property (p_tfs_oe)
    else $error("tx frame enable wrong");
endmodule

bind dssp_top dssp_props #(.DIVW(DIVW)) dssp_props_inst (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .sclk_oe(sclk_oe), .rfs_oe(rfs_oe),
  .tfs_oe(tfs_oe), .dt_o(dt_o), .dt_oe(dt_oe));

/* File: testbench/dssp_far.sv */
// far-end codec model on serial port zero
`timescale 1ns/1ps
module dssp_far #(
  parameter int LEN = 8
) (
  output logic sclk,
  output logic fs,
  output logic dr,
  input wire logic dev_sclk,
  input wire logic dev_fs,
  input wire logic dev_dt,
  output logic [15:0] cap
);
  int n = 0;
  initial
  begin
    sclk = 1'b0;
    fs = 1'b0;
    dr = 1'b0;
    cap = 16'h0000;
  end
  // one framed word, msb first; clock runs for the frame sync cycle, the word and two cycles after it
  task automatic send(input logic [15:0] w, input int len);
    #5; // keep pin changes off the mclk sampling edge
    for (int i = -1; i < len + 2; i++)
    begin
      sclk = 1'b1;
      fs = (i == -1);
      dr = (i >= 0 && i < len) ? w[len - 1 - i] : ~dr;
      #80 sclk = 1'b0;
      #80;
    end
  endtask
  // frame seen at one falling edge, bits on the next ones
  always @(negedge dev_sclk)
    if (n > 0)
    begin
      cap = {cap[14:0], dev_dt};
      n = n - 1;
    end
    else if (dev_fs)
      n = LEN;
endmodule

/* File: testbench/dssp_top_tb_top.sv */
// self-checking bench for the dual serial port block
`timescale 1ns/1ps
module dssp_top_tb_top;
  logic mclk, rst_n, reg_wr, reg_rd, irq;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] sclk_o, sclk_oe, rfs_o, rfs_oe, tfs_o, tfs_oe, dt_o, dt_oe;
  logic far_sclk, far_fs, far_dr, a_n, b_n, flag_in;
  logic [15:0] cap;
  int num_errors = 0;
  int tests_run = 0;
  dssp_top dssp_top_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sclk_i({1'b0, far_sclk}),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .rfs_i({a_n, far_fs}), .rfs_o(rfs_o), .rfs_oe(rfs_oe),
    .tfs_i({b_n, 1'b0}), .tfs_o(tfs_o), .tfs_oe(tfs_oe), .dr_i({flag_in, far_dr}), .dt_o(dt_o),
    .dt_oe(dt_oe));
  dssp_far dssp_far_inst (.sclk(far_sclk), .fs(far_fs), .dr(far_dr), .dev_sclk(sclk_o[0]),
    .dev_fs(tfs_o[0] & tfs_oe[0]), .dev_dt(dt_o[0]), .cap(cap));
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask
  task automatic t_regs;
    rc(7'h24, 32'h0000_0003);
    rc(7'h20, 32'h0000_0000);
    rc(7'h30, 32'h0000_0000);
    rc(7'h7C, 32'h0000_0000);
    wr(7'h24, 32'h0000_0001);
    rc(7'h24, 32'h0000_0001);
  endtask
  task automatic t_tx;
    wr(dssp_pkg::A_IMASK, 32'h0000_0002);
    wr(7'h20, 32'h002F_2000);
    wr(7'h28, 32'h0000_00A5);
    for (int i = 0; i < 2000 && irq !== 1'b1; i++)
      @(posedge mclk);
    repeat (8) @(negedge mclk);
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, cap[7:0]}, 32'hA5);
    chk({30'h0, sclk_oe}, 32'h1);
    rc(dssp_pkg::A_ISTAT, 32'h0000_0002);
    wr(dssp_pkg::A_ISTAT, 32'h0000_0002);
    repeat (3) @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(7'h20, 32'h0000_0000);
  endtask
  task automatic t_rx(input logic [15:0] w, input int len, input logic [1:0] cmp, input logic [15:0] e);
    wr(dssp_pkg::A_ISTAT, 32'h0000_003F);
    wr(7'h20, {16'h0, 4'h0, cmp, 3'h0, 2'h2, 4'(len - 1), 1'b1});
    dssp_far_inst.send(w, len);
    repeat (4) @(negedge mclk);
    rc(dssp_pkg::A_STAT, 32'h0000_0002);
    rc(dssp_pkg::A_ISTAT, 32'h0000_0001);
    rc(7'h2C, {16'h0, e});
    rc(dssp_pkg::A_STAT, 32'h0000_0000);
    wr(7'h20, 32'h0000_0000);
  endtask
  task automatic t_alt;
    wr(dssp_pkg::A_SYS, 32'h0000_000B);
    wr(7'h40, 32'h0000_2000);
    wr(dssp_pkg::A_ISTAT, 32'h0000_003F);
    flag_in <= 1'b1;
    repeat (4) @(negedge mclk);
    chk({29'h0, dt_oe[1], dt_o[1], sclk_oe[1]}, 32'h7);
    rc(dssp_pkg::A_STAT, 32'h0000_0010);
    @(posedge mclk);
    a_n <= 1'b0;
    b_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rc(dssp_pkg::A_ISTAT, 32'h0000_0030);
    wr(dssp_pkg::A_ISTAT, 32'h0000_003F);
    rc(dssp_pkg::A_ISTAT, 32'h0000_0020);
    wr(dssp_pkg::A_IMASK, 32'h0000_0020);
    repeat (3) @(negedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(dssp_pkg::A_IMASK, 32'h0000_0000);
    repeat (3) @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    @(posedge mclk);
    a_n <= 1'b1;
    b_n <= 1'b1;
    wr(dssp_pkg::A_SYS, 32'h0000_0000);
    rc(dssp_pkg::A_SYS, 32'h0000_0000);
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #400000;
    num_errors++;
    final_report;
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    a_n = 1'b1;
    b_n = 1'b1;
    flag_in = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    wr(dssp_pkg::A_ISTAT, 32'h0000_003F);
    t_regs;
    t_tx;
    t_rx(16'hC3A5, 16, 2'h0, 16'hC3A5);
    t_rx(16'h0005, 3, 2'h0, 16'h0005);
    t_rx(16'h0080, 8, dssp_pkg::CMP_MU, 16'h7D7C);
    t_alt;
    final_report;
  end
endmodule
